/* rtl/dcag_consts.vh */
// constants and register map of the dma channel address generator
`ifndef DCAG_CONSTS_VH
`define DCAG_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DCAG_REG_CTRL 4'h0
`define DCAG_REG_STA 4'h1
`define DCAG_REG_STB 4'h2
`define DCAG_REG_PAD 4'h3
`define DCAG_REG_CNT 4'h4
`define DCAG_REG_STAT 4'h5
`define DCAG_REG_SWREQ 4'h6

// ----------------------------------------------------------------
// control field positions, mode codes, increments and reset values
// ----------------------------------------------------------------
`define DCAG_CTL_ADDRESSING_MODE_SELECT_LO 0
`define DCAG_CTL_ADDRESSING_MODE_SELECT_HI 1
`define DCAG_CTL_PINGPONG 2
`define DCAG_CTL_ONESHOT 3
`define DCAG_CTL_HALF 4
`define DCAG_CTL_DIR 13
`define DCAG_CTL_SIZE 14
`define DCAG_CTL_EN 15
`define DCAG_CTL_RST 16'h0000
`define DCAG_ADDRESSING_MODE_SELECT_POSTINC 2'h0
`define DCAG_ADDRESSING_MODE_SELECT_NOINC 2'h1
`define DCAG_INC_WORD 16'h0002
`define DCAG_INC_BYTE 16'h0001
`define DCAG_CNT_RST 10'h000

`endif

/* rtl/dcag_addr_calc.v */
// next-address arithmetic for one dma channel
`timescale 1ns/100ps
`include "dcag_consts.vh"

module dcag_addr_calc (
  input wire [1:0] addressing_mode_select, // addressing mode select
  input wire size_byte, // 1: byte elements
  input wire [15:0] run_addr, // running ram offset
  input wire [15:0] base_addr, // selected start offset
  input wire [15:0] per_addr, // peripheral address, zero-extended
  output reg [15:0] xfer_addr, // offset used by this transfer
  output reg [15:0] next_addr // running offset after it
);
  always @* begin
    if (addressing_mode_select[`DCAG_CTL_ADDRESSING_MODE_SELECT_HI]) begin
      xfer_addr = base_addr | per_addr;
      next_addr = run_addr;
    end else begin
      xfer_addr = run_addr;
      if (addressing_mode_select[`DCAG_CTL_ADDRESSING_MODE_SELECT_LO]) begin
        next_addr = run_addr;
      end else if (size_byte) begin
        next_addr = run_addr + `DCAG_INC_BYTE;
      end else begin
        next_addr = run_addr + `DCAG_INC_WORD;
      end
    end
  end
endmodule

/* rtl/dcag_channel.v */
// one dma channel: registers, block sequencing and ram addressing
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "dcag_consts.vh"

module dcag_channel (
  input wire CLK, // system clock, 100 MHz
  input wire SYS_RST, // async reset, active high
  input wire [3:0] REG_ADDR, // register index
  input wire [15:0] REG_WDATA, // write data
  input wire REG_WR, // write strobe
  input wire REG_RD, // read strobe
  output reg [15:0] REG_RDATA, // read data, cycle after strobe
  input wire PER_REQ, // peripheral request pulse, same clock
  input wire [15:0] PER_ADDR, // peripheral address, unused high 0
  output reg RAM_WE, // ram write strobe
  output reg RAM_RE, // ram read strobe
  output reg [15:0] RAM_ADDR, // ram byte offset
  output reg RAM_BYTE, // byte-sized access
  output reg PERI_WE, // peripheral register write strobe
  output reg PERI_RE, // peripheral register read strobe
  output reg [15:0] PERI_ADDR, // peripheral register address
  output reg IRQ_PULSE, // one-cycle event to interrupt ctrl
  output reg ACTIVE // channel enabled and running
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [15:0] ctrl_q;
  reg [15:0] sta_q;
  reg [15:0] stb_q;
  reg [15:0] pad_q;
  reg [9:0] cnt_q;
  reg [15:0] run_q;
  reg [15:0] last_q;
  reg [9:0] done_q;
  reg buf_b_q;
  reg [2:0] st_q;
  reg swreq_q;
  wire [15:0] xfer_addr;
  wire [15:0] next_addr;
  wire [15:0] base_sel;
  wire req;
  wire blk_end;
  wire half_hit;
  wire [10:0] half_cnt;

  function wr_hit;
    input [3:0] a;
    input [3:0] r;
    begin
      wr_hit = REG_WR && (a == r);
    end
  endfunction

  assign base_sel = buf_b_q ? stb_q : sta_q;
  assign req = (PER_REQ || swreq_q) && (st_q == ST_RUN);
  assign blk_end = (done_q == cnt_q);
  // half point: (cnt+2)/2 transfers, rounds up for odd sizes
  assign half_cnt = ({1'b0, cnt_q} + 11'h002) >> 1;
  assign half_hit = ({1'b0, done_q} + 11'h001) == half_cnt;

  dcag_addr_calc u_calc (
    .addressing_mode_select(ctrl_q[`DCAG_CTL_ADDRESSING_MODE_SELECT_HI:`DCAG_CTL_ADDRESSING_MODE_SELECT_LO]),
    .size_byte(ctrl_q[`DCAG_CTL_SIZE]),
    .run_addr(run_q),
    .base_addr(base_sel),
    .per_addr(PER_ADDR),
    .xfer_addr(xfer_addr),
    .next_addr(next_addr)
  );

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_q <= `DCAG_CTL_RST;
      sta_q <= 16'h0000;
      stb_q <= 16'h0000;
      pad_q <= 16'h0000;
      cnt_q <= `DCAG_CNT_RST;
      swreq_q <= 1'b0;
    end else begin
      if (wr_hit(REG_ADDR, `DCAG_REG_CTRL)) begin
        ctrl_q <= REG_WDATA; // mode change leaves run_q
      end
      // start values are never touched by address advance
      if (wr_hit(REG_ADDR, `DCAG_REG_STA)) begin
        sta_q <= REG_WDATA;
      end
      if (wr_hit(REG_ADDR, `DCAG_REG_STB)) begin
        stb_q <= REG_WDATA;
      end
      if (wr_hit(REG_ADDR, `DCAG_REG_PAD)) begin
        pad_q <= REG_WDATA;
      end
      if (wr_hit(REG_ADDR, `DCAG_REG_CNT)) begin
        cnt_q <= REG_WDATA[9:0];
      end
      if (wr_hit(REG_ADDR, `DCAG_REG_SWREQ)) begin
        swreq_q <= REG_WDATA[0];
      end else if (req) begin
        swreq_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `DCAG_REG_CTRL: REG_RDATA <= ctrl_q;
        // both offset reads show the latest transfer offset
        `DCAG_REG_STA: REG_RDATA <= last_q;
        `DCAG_REG_STB: REG_RDATA <= last_q;
        `DCAG_REG_PAD: REG_RDATA <= pad_q;
        `DCAG_REG_CNT: REG_RDATA <= {6'h00, cnt_q};
        `DCAG_REG_STAT: REG_RDATA <= {3'h0, buf_b_q, 2'h0, done_q};
        default: REG_RDATA <= 16'h0000;
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // block sequencer and address state
  // ----------------------------------------------------------------
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= ST_IDLE;
      run_q <= 16'h0000;
      last_q <= 16'h0000;
      done_q <= 10'h000;
      buf_b_q <= 1'b0;
      RAM_WE <= 1'b0;
      RAM_RE <= 1'b0;
      RAM_ADDR <= 16'h0000;
      RAM_BYTE <= 1'b0;
      PERI_WE <= 1'b0;
      PERI_RE <= 1'b0;
      PERI_ADDR <= 16'h0000;
      IRQ_PULSE <= 1'b0;
      ACTIVE <= 1'b0;
    end else begin
      RAM_WE <= 1'b0;
      RAM_RE <= 1'b0;
      PERI_WE <= 1'b0;
      PERI_RE <= 1'b0;
      IRQ_PULSE <= 1'b0;
      ACTIVE <= ctrl_q[`DCAG_CTL_EN] && (st_q != ST_IDLE);
      case (st_q)
        ST_IDLE: begin
          buf_b_q <= 1'b0;
          if (ctrl_q[`DCAG_CTL_EN]) begin
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          run_q <= base_sel;
          done_q <= 10'h000;
          st_q <= ST_RUN;
        end
        ST_RUN: begin
          if (!ctrl_q[`DCAG_CTL_EN]) begin
            st_q <= ST_IDLE;
          end else if (req) begin
            // same sequencing whatever the addressing mode
            RAM_ADDR <= xfer_addr;
            RAM_BYTE <= ctrl_q[`DCAG_CTL_SIZE];
            PERI_ADDR <= pad_q;
            RAM_RE <= ctrl_q[`DCAG_CTL_DIR];
            PERI_WE <= ctrl_q[`DCAG_CTL_DIR];
            RAM_WE <= !ctrl_q[`DCAG_CTL_DIR];
            PERI_RE <= !ctrl_q[`DCAG_CTL_DIR];
            last_q <= xfer_addr;
            run_q <= next_addr;
            done_q <= done_q + 10'h001;
            // flag clearing is the interrupt controller's job
            IRQ_PULSE <= ctrl_q[`DCAG_CTL_HALF] ? half_hit
                                                : blk_end;
            if (blk_end) begin
              if (ctrl_q[`DCAG_CTL_PINGPONG]) begin
                buf_b_q <= !buf_b_q;
              end
              if (ctrl_q[`DCAG_CTL_ONESHOT] &&
                  (!ctrl_q[`DCAG_CTL_PINGPONG] || buf_b_q)) begin
                st_q <= ST_IDLE;
              end else begin
                st_q <= ST_LOAD;
              end
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule

/* testbench/dcag_checker.sv */
// assertions on the dma channel ports
`timescale 1ns/100ps
module dcag_checker (
  input wire CLK, // clock
  input wire SYS_RST, // reset
  input wire REG_RD, // read strobe
  input wire [15:0] REG_RDATA, // read data
  input wire RAM_WE, // ram write
  input wire RAM_RE, // ram read
  input wire [15:0] RAM_ADDR, // ram offset
  input wire PERI_WE, // peripheral write
  input wire PERI_RE, // peripheral read
  input wire IRQ_PULSE, // interrupt event
  input wire ACTIVE // running
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire xf = RAM_WE | RAM_RE;
  chk_one_side: assert property (!(RAM_WE && RAM_RE))
    else $error("ram read and write at once");
  chk_wr_pair: assert property (RAM_WE |-> PERI_RE && !PERI_WE)
    else $error("ram write without peripheral read");
  chk_rd_pair: assert property (RAM_RE |-> PERI_WE && !PERI_RE)
    else $error("ram read without peripheral write");
  chk_irq_xfer: assert property (IRQ_PULSE |-> xf)
    else $error("interrupt without transfer");
  chk_addr_hold: assert property (!xf |-> $stable(RAM_ADDR))
    else $error("ram address moved without transfer");
  chk_run_only: assert property (xf |-> $past(ACTIVE))
    else $error("transfer while idle");
  chk_rd_quiet: assert property (!$past(REG_RD) |-> !(|REG_RDATA))
    else $error("read data outside read cycle");
  chk_reset_quiet: assert property ($fell(SYS_RST) |-> !ACTIVE && !xf)
    else $error("activity right after reset");
endmodule
bind dcag_channel dcag_checker dcag_checker_inst (.CLK(CLK),
  .SYS_RST(SYS_RST), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .RAM_WE(RAM_WE), .RAM_RE(RAM_RE), .RAM_ADDR(RAM_ADDR),
  .PERI_WE(PERI_WE), .PERI_RE(PERI_RE), .IRQ_PULSE(IRQ_PULSE),
  .ACTIVE(ACTIVE));

/* testbench/dcag_peri_model.sv */
// requesting peripheral that hands an address with each request
`timescale 1ns/100ps
module dcag_peri_model (
  input wire CLK, // clock
  input wire issue, // raise one request
  input wire [15:0] addr, // address for it, own width zero-extended
  output reg PER_REQ = 1'b0, // request pulse
  output reg [15:0] PER_ADDR = 16'h0000 // address with request
);
  // outside a request the address flips so stale values never match
  always @(posedge CLK) begin
    PER_REQ <= issue;
    PER_ADDR <= issue ? addr : ~PER_ADDR;
  end
endmodule

/* testbench/dcag_channel_test.sv */
// self-checking bench for the dma channel
`timescale 1ns/100ps
module dcag_channel_test;
  reg CLK = 1'b0;
  reg SYS_RST = 1'b1;
  reg REG_WR = 1'b0;
  reg REG_RD = 1'b0;
  reg [3:0] REG_ADDR = 4'h0;
  reg [15:0] REG_WDATA = 16'h0000;
  reg issue = 1'b0;
  reg [15:0] paddr = 16'h0000;
  reg dir = 1'b0;
  reg sz = 1'b0;
  wire [15:0] REG_RDATA, RAM_ADDR, PERI_ADDR, PER_ADDR;
  wire PER_REQ, RAM_WE, RAM_RE, RAM_BYTE;
  wire PERI_WE, PERI_RE, IRQ_PULSE, ACTIVE;
  integer mismatches = 0;
  integer n_compared = 0;
  initial forever #5 CLK = ~CLK;
  dcag_channel dcag_channel_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PER_REQ(PER_REQ),
    .PER_ADDR(PER_ADDR), .RAM_WE(RAM_WE), .RAM_RE(RAM_RE),
    .RAM_ADDR(RAM_ADDR), .RAM_BYTE(RAM_BYTE), .PERI_WE(PERI_WE),
    .PERI_RE(PERI_RE), .PERI_ADDR(PERI_ADDR), .IRQ_PULSE(IRQ_PULSE),
    .ACTIVE(ACTIVE));
  dcag_peri_model dcag_peri_model_inst (.CLK(CLK), .issue(issue),
    .addr(paddr), .PER_REQ(PER_REQ), .PER_ADDR(PER_ADDR));
  task complete_run;
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [63:0] what, input [15:0] exp, input [15:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value %0s exp %h got %h", what, exp, got);
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task rd(input [3:0] a, input [15:0] exp);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 chk("rdata", exp, REG_RDATA);
  endtask
  // one peripheral request, judged in the cycle its strobes stand
  task xfer(input [15:0] pa, input [15:0] ea, input irq);
    integer n;
    @(posedge CLK);
    issue <= 1'b1;
    paddr <= pa;
    @(posedge CLK);
    issue <= 1'b0;
    for (n = 0; n < 4 && RAM_WE !== 1'b1 && RAM_RE !== 1'b1; n = n + 1)
      @(posedge CLK) #1;
    if (n == 4) begin
      chk("timeout", 16'h0000, 16'h0001);
      complete_run;
    end
    chk("ram_addr", ea, RAM_ADDR);
    chk("strobes", {11'h000, ~dir, dir, dir, ~dir, sz},
      {11'h000, RAM_WE, RAM_RE, PERI_WE, PERI_RE, RAM_BYTE});
    chk("irq", {15'h0000, irq}, {15'h0000, IRQ_PULSE});
    chk("peri_adr", 16'h0010, PERI_ADDR);
    chk("active", 16'h0001, {15'h0000, ACTIVE});
    // event lasts one cycle; the flag lives in the interrupt ctrl
    @(posedge CLK) #1;
    chk("irq_drop", 16'h0000, {15'h0000, IRQ_PULSE});
  endtask
  task s_postinc;
    rd(4'h0, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(4'h3, 16'h0010);
    wr(4'h1, 16'h0100);
    wr(4'h4, 16'h0002);
    wr(4'h0, 16'h8000);
    xfer(16'h0005, 16'h0100, 1'b0);
    xfer(16'h0005, 16'h0102, 1'b0);
    xfer(16'h0005, 16'h0104, 1'b1);
    xfer(16'h0005, 16'h0100, 1'b0);
    rd(4'h1, 16'h0100);
  endtask
  task s_byte;
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0201);
    wr(4'h4, 16'h0003);
    sz = 1'b1;
    wr(4'h0, 16'hc000);
    xfer(16'h0000, 16'h0201, 1'b0);
    xfer(16'h0000, 16'h0202, 1'b0);
    wr(4'h0, 16'hc001);
    xfer(16'h0000, 16'h0203, 1'b0);
    xfer(16'h0000, 16'h0203, 1'b1);
  endtask
  // base low bits kept clear so the or is exact
  task s_indirect(input [1:0] m);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0300);
    wr(4'h4, 16'h0001);
    sz = 1'b0;
    dir = 1'b1;
    wr(4'h0, {14'h2800, m});
    xfer(16'h0007, 16'h0307, 1'b0);
    xfer(16'h000c, 16'h030c, 1'b1);
    rd(4'h1, 16'h030c);
  endtask
  // ping-pong with half interrupt, then one software request
  task s_pingpong;
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0400);
    wr(4'h2, 16'h0500);
    wr(4'h4, 16'h0002);
    dir = 1'b0;
    wr(4'h0, 16'h8014);
    xfer(16'h0000, 16'h0400, 1'b0);
    xfer(16'h0000, 16'h0402, 1'b1);
    xfer(16'h0000, 16'h0404, 1'b0);
    xfer(16'h0000, 16'h0500, 1'b0);
    wr(4'h6, 16'h0001);
    @(posedge CLK) #1;
    chk("sw_addr", 16'h0502, RAM_ADDR);
    chk("sw_we", 16'h0001, {15'h0000, RAM_WE});
    rd(4'h5, 16'h1002);
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    s_postinc;
    s_byte;
    s_indirect(2'h2);
    s_indirect(2'h3);
    s_pingpong;
    complete_run;
  end
endmodule
